// ---- common/rfpa_defs.svh ----
// register offsets, field positions, reset values and timing counts for the
// front-end power select and synthesizer calibration register bank
// assumes: included by bare name from the rfpa_regs design module only
`ifndef RFPA_DEFS_SVH
`define RFPA_DEFS_SVH

// ---------------------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------------------
`define RFPA_ADDR_RX_BIAS      6'h21
`define RFPA_ADDR_TX_PWR_SEL   6'h22
`define RFPA_ADDR_SYNTH_CAL_A  6'h23

// ---------------------------------------------------------------------------
// reset values and writable-bit masks
// ---------------------------------------------------------------------------
`define RFPA_RST_RX_BIAS       8'h56
`define RFPA_RST_TX_PWR_SEL    8'h10
`define RFPA_RST_SYNTH_CAL_A   8'ha9
`define RFPA_MASK_RX_BIAS      8'hff
`define RFPA_MASK_TX_PWR_SEL   8'h37
`define RFPA_MASK_SYNTH_CAL_A  8'hff

// ---------------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------------
`define RFPA_LNA_BIAS_MSB      7
`define RFPA_LNA_BIAS_LSB      6
`define RFPA_MIX_FEED_MSB      5
`define RFPA_MIX_FEED_LSB      4
`define RFPA_RX_LO_MSB         3
`define RFPA_RX_LO_LSB         2
`define RFPA_MIXER_MSB         1
`define RFPA_MIXER_LSB         0
`define RFPA_TX_LO_MSB         5
`define RFPA_TX_LO_LSB         4
`define RFPA_AMP_IDX_MSB       2
`define RFPA_AMP_IDX_LSB       0
`define RFPA_CAL_CFG_MSB       7
`define RFPA_CAL_CFG_LSB       6
`define RFPA_CP_EN_MSB         5
`define RFPA_CP_EN_LSB         4
`define RFPA_CP_RES_MSB        3
`define RFPA_CP_RES_LSB        0
`define RFPA_CP_EN_ON          2'h1

// ---------------------------------------------------------------------------
// timing counts in ref_clk cycles, and the power table depth in entries
// ---------------------------------------------------------------------------
`define RFPA_RAMP_DIV          16
`define RFPA_TABLE_DEPTH       8
`define RFPA_VCO_STAGE_CYC     64
`define RFPA_CP_STAGE_CYC      64

`endif

// ---- common/rfpa_pkg.sv ----
// types shared by the power select and calibration register bank
// assumes: nothing beyond the defs header
package rfpa_pkg;
    // synthesizer calibration sequencer states
    typedef enum logic [1:0] {
        RFPA_CAL_IDLE,
        RFPA_CAL_VCO,
        RFPA_CAL_CP,
        RFPA_CAL_DONE
    } rfpa_cal_state_t;
endpackage : rfpa_pkg

// ---- rtl/rfpa_table_mem.sv ----
// power level table: small memory with one write port and a registered read
// assumes: one clock, write and read may hit the same entry in one cycle
`timescale 1ns/1ps
module rfpa_table_mem #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic                     ref_clk,
    input  wire logic                     sys_rst,
    // write port
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
    input  wire logic [WIDTH-1:0]         wr_data,
    // read port
    input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
    output logic      [WIDTH-1:0]         rd_data_q
);
    logic [WIDTH-1:0] mem_q [DEPTH];

    // index ports need at least one bit
    if (DEPTH < 2 || WIDTH < 1) begin : g_bad_param
        $error("rfpa_table_mem: unsupported parameter value");
    end

    // storage has no reset; contents are software's to load
    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem_q[wr_idx] <= wr_data;
        end
    end

    // read data from a flop so the amplifier setting never glitches
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data_q <= '0;
        end else begin
            rd_data_q <= mem_q[rd_idx];
        end
    end
endmodule : rfpa_table_mem

// ---- rtl/rfpa_regs.sv ----
// front-end bias trims, power table entry selection with ramping, and the
// charge pump calibration result register with a small calibration sequencer
// assumes: register port is synchronous to ref_clk; analog side supplies a
// charge pump code and consumes the bias fields and table setting
`timescale 1ns/1ps
`include "rfpa_defs.svh"
module rfpa_regs
    import rfpa_pkg::*;
#(
    parameter int RAMP_DIV     = `RFPA_RAMP_DIV,
    parameter int VCO_STAGE    = `RFPA_VCO_STAGE_CYC,
    parameter int CP_STAGE     = `RFPA_CP_STAGE_CYC,
    parameter int TABLE_DEPTH  = `RFPA_TABLE_DEPTH
) (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    // register port
    input  wire logic [5:0] reg_addr,
    input  wire logic       reg_wr_en,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_rd_en,
    output logic      [7:0] reg_rdata_q,
    // power table load port
    input  wire logic       tbl_wr_en,
    input  wire logic [2:0] tbl_wr_idx,
    input  wire logic [7:0] tbl_wdata,
    // transmit control
    input  wire logic       tx_active,
    input  wire logic       tx_keyed_mode,
    input  wire logic       tx_symbol,
    output logic      [2:0] pa_entry_q,
    output logic      [7:0] pa_setting_q,
    output logic            pa_ramp_idle,
    // calibration control
    input  wire logic       cal_start,
    input  wire logic [3:0] cal_cp_code,
    output logic            cal_busy,
    output logic            cal_cp_stage,
    // front-end trims
    output logic      [1:0] low_noise_amp_bias,
    output logic      [1:0] amp_to_mixer_bias,
    output logic      [1:0] rx_local_osc_buffer_bias,
    output logic      [1:0] mixer_bias,
    output logic      [1:0] tx_local_osc_buffer_bias,
    output logic      [2:0] amp_level_index,
    output logic      [1:0] synth_cal_config,
    output logic      [1:0] charge_pump_cal_enable,
    output logic      [3:0] synth_cal_result_a
);
    // ------------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------------
    // counters are 16 bits wide and the entry register holds only 3 bits
    if (RAMP_DIV < 1 || RAMP_DIV > 65536 || VCO_STAGE < 1 || CP_STAGE < 1
        || VCO_STAGE > 65536 || CP_STAGE > 65536 || TABLE_DEPTH != 8) begin : g_bad_param
        $error("rfpa_regs: unsupported parameter value");
    end

    logic [7:0]      rx_bias_q;
    logic [7:0]      tx_sel_q;
    logic [7:0]      cal_a_q;
    logic [15:0]     ramp_cnt_q;
    logic            ramp_tick;
    logic [2:0]      target;
    rfpa_cal_state_t cal_state_q;
    logic [15:0]     stage_cnt_q;
    logic            cp_run_q;
    logic            cp_load;

    // ------------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------------
    // writable-bit mask per offset; zero marks an unmapped offset
    function automatic logic [7:0] reg_mask(input logic [5:0] a);
        unique case (a)
            `RFPA_ADDR_RX_BIAS:     reg_mask = `RFPA_MASK_RX_BIAS;
            `RFPA_ADDR_TX_PWR_SEL:  reg_mask = `RFPA_MASK_TX_PWR_SEL;
            `RFPA_ADDR_SYNTH_CAL_A: reg_mask = `RFPA_MASK_SYNTH_CAL_A;
            default:                reg_mask = 8'h00;
        endcase
    endfunction : reg_mask

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_bias_q <= `RFPA_RST_RX_BIAS;
        end else if (reg_wr_en && reg_addr == `RFPA_ADDR_RX_BIAS) begin
            rx_bias_q <= reg_wdata & reg_mask(reg_addr);
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_sel_q <= `RFPA_RST_TX_PWR_SEL;
        end else if (reg_wr_en && reg_addr == `RFPA_ADDR_TX_PWR_SEL) begin
            tx_sel_q <= reg_wdata & reg_mask(reg_addr);
        end
    end

    // result readable and writable
    // the sequencer's load wins over a software write to the result bits in the same cycle,
    // since a fresh measurement is worth more than a stale restore
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cal_a_q <= `RFPA_RST_SYNTH_CAL_A;
        end else begin
            if (reg_wr_en && reg_addr == `RFPA_ADDR_SYNTH_CAL_A) begin
                cal_a_q <= reg_wdata & reg_mask(reg_addr);
            end
            if (cp_load) begin
                cal_a_q[`RFPA_CP_RES_MSB:`RFPA_CP_RES_LSB] <= cal_cp_code;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_rd_en) begin
            unique case (reg_addr)
                `RFPA_ADDR_RX_BIAS:     reg_rdata_q <= rx_bias_q & reg_mask(reg_addr);
                `RFPA_ADDR_TX_PWR_SEL:  reg_rdata_q <= tx_sel_q & reg_mask(reg_addr);
                `RFPA_ADDR_SYNTH_CAL_A: reg_rdata_q <= cal_a_q & reg_mask(reg_addr);
                default:                reg_rdata_q <= 8'h00;
            endcase
        end
    end

    // field outputs straight from the register flops
    assign low_noise_amp_bias       = rx_bias_q[`RFPA_LNA_BIAS_MSB:`RFPA_LNA_BIAS_LSB];
    assign amp_to_mixer_bias        = rx_bias_q[`RFPA_MIX_FEED_MSB:`RFPA_MIX_FEED_LSB];
    assign rx_local_osc_buffer_bias = rx_bias_q[`RFPA_RX_LO_MSB:`RFPA_RX_LO_LSB];
    assign mixer_bias               = rx_bias_q[`RFPA_MIXER_MSB:`RFPA_MIXER_LSB];
    assign tx_local_osc_buffer_bias = tx_sel_q[`RFPA_TX_LO_MSB:`RFPA_TX_LO_LSB];
    assign amp_level_index          = tx_sel_q[`RFPA_AMP_IDX_MSB:`RFPA_AMP_IDX_LSB];
    assign synth_cal_config         = cal_a_q[`RFPA_CAL_CFG_MSB:`RFPA_CAL_CFG_LSB];
    assign charge_pump_cal_enable   = cal_a_q[`RFPA_CP_EN_MSB:`RFPA_CP_EN_LSB];
    assign synth_cal_result_a       = cal_a_q[`RFPA_CP_RES_MSB:`RFPA_CP_RES_LSB];

    // ------------------------------------------------------------------
    // power table stepping
    // ------------------------------------------------------------------
    // ramp step rate: one-cycle enable from a free divider
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ramp_cnt_q <= 16'h0000;
        end else if (ramp_tick) begin
            ramp_cnt_q <= 16'h0000;
        end else begin
            ramp_cnt_q <= ramp_cnt_q + 16'h0001;
        end
    end
    assign ramp_tick = (ramp_cnt_q == 16'(RAMP_DIV - 1));

    always_comb begin
        if (!tx_active || (tx_keyed_mode && !tx_symbol)) begin
            target = 3'h0;
        end else begin
            target = amp_level_index;
        end
    end

    // step one entry per tick
    // walking one entry at a time gives the shaped edge and the ramps alike;
    // an index lowered mid-frame walks down the same way, never jumps
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pa_entry_q <= 3'h0;
        end else if (ramp_tick) begin
            if (pa_entry_q < target) begin
                pa_entry_q <= pa_entry_q + 3'h1;
            end else if (pa_entry_q > target) begin
                pa_entry_q <= pa_entry_q - 3'h1;
            end
        end
    end
    assign pa_ramp_idle = (pa_entry_q == target);

    rfpa_table_mem #(
        .DEPTH (TABLE_DEPTH),
        .WIDTH (8)
    ) u_table (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .wr_en     (tbl_wr_en),
        .wr_idx    (tbl_wr_idx),
        .wr_data   (tbl_wdata),
        .rd_idx    (pa_entry_q),
        .rd_data_q (pa_setting_q)
    );

    // ------------------------------------------------------------------
    // calibration sequencer
    // ------------------------------------------------------------------
    // charge pump stage gated
    // enable is sampled at start so a mid-run write cannot split a stage
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cal_state_q <= RFPA_CAL_IDLE;
            stage_cnt_q <= 16'h0000;
            cp_run_q    <= 1'b0;
        end else begin
            unique case (cal_state_q)
                RFPA_CAL_IDLE: begin
                    if (cal_start) begin
                        cal_state_q <= RFPA_CAL_VCO;
                        stage_cnt_q <= 16'(VCO_STAGE - 1);
                        cp_run_q    <= (charge_pump_cal_enable == `RFPA_CP_EN_ON);
                    end
                end
                RFPA_CAL_VCO: begin
                    if (stage_cnt_q != 16'h0000) begin
                        stage_cnt_q <= stage_cnt_q - 16'h0001;
                    end else if (cp_run_q) begin
                        cal_state_q <= RFPA_CAL_CP;
                        stage_cnt_q <= 16'(CP_STAGE - 1);
                    end else begin
                        cal_state_q <= RFPA_CAL_DONE;
                    end
                end
                RFPA_CAL_CP: begin
                    if (stage_cnt_q != 16'h0000) begin
                        stage_cnt_q <= stage_cnt_q - 16'h0001;
                    end else begin
                        cal_state_q <= RFPA_CAL_DONE;
                    end
                end
                RFPA_CAL_DONE: begin
                    cal_state_q <= RFPA_CAL_IDLE;
                end
            endcase
        end
    end
    assign cp_load      = (cal_state_q == RFPA_CAL_CP) && (stage_cnt_q == 16'h0000);
    assign cal_busy     = (cal_state_q != RFPA_CAL_IDLE);
    assign cal_cp_stage = (cal_state_q == RFPA_CAL_CP);

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence s_cp_last;
        cal_state_q == RFPA_CAL_CP && stage_cnt_q == 16'h0000;
    endsequence
    sequence s_vco_last_no_cp;
        cal_state_q == RFPA_CAL_VCO && stage_cnt_q == 16'h0000 && !cp_run_q;
    endsequence

    property p_reserved_zero;
        reg_rd_en && reg_addr == `RFPA_ADDR_TX_PWR_SEL |=> (reg_rdata_q & 8'hc8) == 8'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits read nonzero");

    property p_index_write;
        reg_wr_en && reg_addr == `RFPA_ADDR_TX_PWR_SEL |=> amp_level_index == $past(reg_wdata[2:0]);
    endproperty
    a_index_write: assert property (p_index_write)
        else $error("index field not stored");

    property p_one_steps_up;
        ramp_tick && tx_active && tx_keyed_mode && tx_symbol && pa_entry_q < amp_level_index
        |=> pa_entry_q == $past(pa_entry_q) + 3'h1;
    endproperty
    a_one_steps_up: assert property (p_one_steps_up)
        else $error("one symbol did not step toward index");

    property p_zero_steps_down;
        ramp_tick && tx_active && tx_keyed_mode && !tx_symbol && pa_entry_q != 3'h0
        |=> pa_entry_q == $past(pa_entry_q) - 3'h1;
    endproperty
    a_zero_steps_down: assert property (p_zero_steps_down)
        else $error("zero symbol did not step toward entry zero");

    property p_ramp_only_on_tick;
        pa_entry_q != $past(pa_entry_q) |-> $past(ramp_tick);
    endproperty
    a_ramp_only_on_tick: assert property (p_ramp_only_on_tick)
        else $error("entry moved without ramp tick");

    property p_ramp_down_end;
        ramp_tick && !tx_active && pa_entry_q != 3'h0 |=> pa_entry_q == $past(pa_entry_q) - 3'h1;
    endproperty
    a_ramp_down_end: assert property (p_ramp_down_end)
        else $error("no ramp down after transmit end");

    property p_cp_load;
        s_cp_last |=> synth_cal_result_a == $past(cal_cp_code);
    endproperty
    a_cp_load: assert property (p_cp_load)
        else $error("calibration result not loaded");

    property p_cp_skip;
        s_vco_last_no_cp |=> cal_state_q == RFPA_CAL_DONE ##1 cal_state_q == RFPA_CAL_IDLE;
    endproperty
    a_cp_skip: assert property (p_cp_skip)
        else $error("charge pump stage ran while disabled");
endmodule : rfpa_regs

// ---- sim/tb_rfpa_regs.sv ----
// self-checking bench for the power select and calibration register bank
// assumes: design top rfpa_regs with short ramp and stage counts
`timescale 1ns/1ps
module tb_rfpa_regs;
    import rfpa_pkg::*;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic       ref_clk, sys_rst, reg_wr_en, reg_rd_en, tbl_wr_en;
    logic       tx_active, tx_keyed_mode, tx_symbol, cal_start;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata_q, tbl_wdata, pa_setting_q;
    logic [2:0] tbl_wr_idx, pa_entry_q, amp_level_index;
    logic [3:0] cal_cp_code, synth_cal_result_a;
    logic       pa_ramp_idle, cal_busy, cal_cp_stage;
    logic [1:0] low_noise_amp_bias, amp_to_mixer_bias, rx_local_osc_buffer_bias;
    logic [1:0] mixer_bias, tx_local_osc_buffer_bias, synth_cal_config;
    logic [1:0] charge_pump_cal_enable;
    int         num_errors, comparisons, seed, cycles;
    logic [7:0] table_q [8];
    logic [7:0] shadow [3];

    rfpa_regs #(.RAMP_DIV(2), .VCO_STAGE(2), .CP_STAGE(2), .TABLE_DEPTH(8)) dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
        .reg_rdata_q(reg_rdata_q), .tbl_wr_en(tbl_wr_en), .tbl_wr_idx(tbl_wr_idx),
        .tbl_wdata(tbl_wdata), .tx_active(tx_active), .tx_keyed_mode(tx_keyed_mode),
        .tx_symbol(tx_symbol), .pa_entry_q(pa_entry_q), .pa_setting_q(pa_setting_q),
        .pa_ramp_idle(pa_ramp_idle), .cal_start(cal_start), .cal_cp_code(cal_cp_code),
        .cal_busy(cal_busy), .cal_cp_stage(cal_cp_stage),
        .low_noise_amp_bias(low_noise_amp_bias), .amp_to_mixer_bias(amp_to_mixer_bias),
        .rx_local_osc_buffer_bias(rx_local_osc_buffer_bias), .mixer_bias(mixer_bias),
        .tx_local_osc_buffer_bias(tx_local_osc_buffer_bias),
        .amp_level_index(amp_level_index), .synth_cal_config(synth_cal_config),
        .charge_pump_cal_enable(charge_pump_cal_enable),
        .synth_cal_result_a(synth_cal_result_a)
    );

    // ------------------------------------------------------------------
    // clock and hang guard
    // ------------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // the whole run needs a few hundred cycles; this ceiling is generous
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            summarize();
        end
    end

    // ------------------------------------------------------------------
    // shared tasks and expectations
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // writable bits per offset; anything unmapped reads zero
    function automatic logic [7:0] wr_mask(input logic [5:0] a);
        case (a)
            6'h21:   return 8'hff;
            6'h22:   return 8'h37;
            6'h23:   return 8'hff;
            default: return 8'h00;
        endcase
    endfunction : wr_mask

    task automatic reg_write(input logic [5:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(negedge ref_clk);
        reg_wr_en = 1'b0;
        if (a >= 6'h21 && a <= 6'h23) shadow[a-6'h21] = d & wr_mask(a);
    endtask : reg_write

    task automatic reg_check(input logic [5:0] a);
        logic [7:0] e;
        e = (a >= 6'h21 && a <= 6'h23) ? shadow[a-6'h21] : 8'h00;
        @(negedge ref_clk);
        reg_addr  = a;
        reg_rd_en = 1'b1;
        @(negedge ref_clk);
        reg_rd_en = 1'b0;
        check("reg_rdata_q", e, reg_rdata_q);
    endtask : reg_check

    // field outputs must mirror the shadow copies bit for bit
    task automatic check_fields();
        check("front_end_rx", shadow[0], {low_noise_amp_bias, amp_to_mixer_bias,
              rx_local_osc_buffer_bias, mixer_bias});
        check("front_end_tx", shadow[1], {2'h0, tx_local_osc_buffer_bias, 1'b0,
              amp_level_index});
        check("synth_cal", shadow[2], {synth_cal_config, charge_pump_cal_enable,
              synth_cal_result_a});
    endtask : check_fields

    // watch every step of a ramp: one entry a time, setting one cycle behind
    task automatic ramp_to(input logic [2:0] tgt);
        logic [2:0] prev;
        int         n;
        prev = pa_entry_q;
        n = 0;
        while (pa_entry_q !== tgt && n < 200) begin
            @(negedge ref_clk);
            n++;
            check("pa_setting_q", table_q[prev], pa_setting_q);
            check("pa_ramp_idle", {7'h0, pa_entry_q == tgt}, {7'h0, pa_ramp_idle});
            if (pa_entry_q !== prev)
                check("pa_step", {5'h0, (prev < tgt) ? prev + 3'h1 : prev - 3'h1},
                      {5'h0, pa_entry_q});
            prev = pa_entry_q;
        end
        @(negedge ref_clk);
        check("pa_entry_q", {5'h0, tgt}, {5'h0, pa_entry_q});
        check("pa_setting_q", table_q[tgt], pa_setting_q);
        check("pa_ramp_idle", 8'h01, {7'h0, pa_ramp_idle});
    endtask : ramp_to

    // one calibration run; a second start while busy must be dropped
    task automatic calibrate(input logic [1:0] en, input logic [3:0] code);
        logic saw_cp;
        int   n;
        saw_cp = 1'b0;
        reg_write(6'h23, {2'h2, en, ~code});
        @(negedge ref_clk);
        cal_start   = 1'b1;
        cal_cp_code = code;
        @(negedge ref_clk);
        cal_start = 1'b0;
        n = 0;
        while (cal_busy === 1'b1 && n < 100) begin
            saw_cp |= cal_cp_stage;
            cal_start = (n == 1);
            @(negedge ref_clk);
            n++;
        end
        cal_start = 1'b0;
        check("cal_cp_stage_seen", {7'h0, en == 2'h1}, {7'h0, saw_cp});
        repeat (3) @(negedge ref_clk);
        check("cal_busy_after", 8'h00, {7'h0, cal_busy});
        if (en == 2'h1) shadow[2][3:0] = code;
        reg_check(6'h23);
        check_fields();
    endtask : calibrate

    task automatic summarize();
        if (num_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [5:0] a;
        logic [7:0] saved;
        seed = 15;
        {sys_rst, reg_wr_en, reg_rd_en, tbl_wr_en, cal_start} = 5'h10;
        {tx_active, tx_keyed_mode, tx_symbol} = 3'h0;
        {reg_addr, reg_wdata, tbl_wr_idx, tbl_wdata, cal_cp_code} = '0;
        shadow = '{8'h56, 8'h10, 8'ha9};
        repeat (2) @(negedge ref_clk);
        sys_rst = 1'b0;
        check_fields();
        for (int i = 6'h20; i <= 6'h24; i++) reg_check(6'(i));
        // random writes and reads
        // unmapped offsets among them; all draws come from the one seeded stream
        for (int i = 0; i < 60; i++) begin
            a = ($random(seed) & 3) == 0 ? 6'($random(seed))
                                         : 6'h21 + 6'({$random(seed)} % 3);
            if ($random(seed) & 1) reg_write(a, 8'($random(seed)));
            reg_check(a);
        end
        check_fields();
        // load all eight table entries before any transmission
        for (int i = 0; i < 8; i++) begin
            @(negedge ref_clk);
            tbl_wr_en  = 1'b1;
            tbl_wr_idx = 3'(i);
            tbl_wdata  = 8'($random(seed));
            table_q[i] = tbl_wdata;
        end
        @(negedge ref_clk);
        tbl_wr_en = 1'b0;
        tx_active = 1'b0;
        ramp_to(3'h0);
        tx_active = 1'b1;
        foreach (table_q[i]) begin
            reg_write(6'h22, {2'h3, 2'($random(seed)), 1'b1, 3'(7 - i)});
            ramp_to(3'(7 - i));
        end
        reg_write(6'h22, 8'h06);
        ramp_to(3'h6);
        tx_keyed_mode = 1'b1;
        for (int i = 0; i < 6; i++) begin
            tx_symbol = i[0];
            ramp_to(i[0] ? 3'h6 : 3'h0);
        end
        tx_active = 1'b0;
        ramp_to(3'h0);
        for (int i = 0; i < 4; i++) calibrate(2'(i), 4'($random(seed)));
        saved = shadow[2];
        reg_write(6'h23, ~saved);
        reg_check(6'h23);
        reg_write(6'h23, saved);
        reg_check(6'h23);
        summarize();
    end
endmodule : tb_rfpa_regs
